// [pkg/pulse_cfg_params.svh]
// constants for the reference-pulse configuration block
`ifndef PULSE_CFG_PARAMS_SVH
`define PULSE_CFG_PARAMS_SVH
`define REG_GEAR_ENC 4'h0
`define REG_COMP 4'h1
`define REG_STOP_PULSE 4'h2
`define REG_FF_MODE 4'h3
`define REG_NUM_FIRST 4'h4
`define REG_NUM_SECOND 4'h5
`define REG_COMP_STRENGTH 4'h6
`define REG_POS_COUNT 4'h7
`define REG_STATUS 4'h8
`define REG_FIFO_DATA 4'h9
`define RST_GEAR_ENC 16'h0000
`define RST_COMP 16'h0000
`define RST_STOP_PULSE 16'h0000
`define RST_FF_MODE 16'h0000
`define RST_NUM_FIRST 16'h0001
`define RST_NUM_SECOND 16'h0001
`define RST_COMP_STRENGTH 16'h0000
`define GEAR_QUIET_NS 1000000
`define CLK_PERIOD_NS 50
`define GEAR_QUIET_CYC ((`GEAR_QUIET_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// [pkg/pulse_cfg_pkg.sv]
// types for the reference-pulse configuration block
package pulse_cfg_pkg;
  typedef struct packed {
    logic [3:0] invert;
    logic [3:0] form;
    logic [3:0] clear;
    logic [3:0] stop;
  } stop_pulse_t;
  typedef struct packed {
    logic pulse_in;
    logic dir_in;
  } ref_pins_t;
  typedef struct packed {
    logic dyn_brake;
    logic coast;
    logic plug_brake;
    logic zero_clamp;
  } stop_out_t;
endpackage : pulse_cfg_pkg

// [design/step_fifo.sv]
// small flip-flop fifo with valid/ready on both sides
`timescale 1ns/100ps
module step_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_r;
  logic [AW-1:0] rd_r;
  logic [AW:0] cnt_r;
  logic push;
  logic pop;
  assign in_ready = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_r[rd_r];
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_r[wr_r] <= in_data;
    end
  end
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wr_r <= (wr_r == AW'(DEPTH-1)) ? '0 : wr_r + 1'b1;
      end
      if (pop) begin
        rd_r <= (rd_r == AW'(DEPTH-1)) ? '0 : rd_r + 1'b1;
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : step_fifo

// [design/servo_reference_pulse_config.sv]
// reference pulse decode, error counter clear, stop mode and gear select
//
// Decided for this implementation: the register addresses and the strobed register port.
`timescale 1ns/100ps
`include "pulse_cfg_params.svh"
module servo_reference_pulse_config #(
  parameter int GEAR_QUIET_CYCLES = `GEAR_QUIET_CYC,
  parameter int FIFO_DEPTH = 4
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [15:0] rdata,
  input wire pulse_cfg_pkg::ref_pins_t reference_pulse_line,
  input wire logic gear_switch_input,
  input wire logic servo_on,
  input wire logic overtravel,
  output logic [15:0] gear_numerator,
  output logic gear_seq_error,
  output pulse_cfg_pkg::stop_out_t stop_action,
  output logic dynamic_brake,
  output logic absolute_mode,
  output logic low_speed_comp_en,
  output logic [15:0] low_speed_comp_level,
  output logic overload_enhance,
  output logic high_speed_ff,
  output logic analog_ff_en,
  output logic [15:0] pos_error
);
  // ****************************************
  // registers
  // ****************************************
  logic [15:0] gear_encoder_option_param_r;
  logic [15:0] compensation_option_param_r;
  pulse_cfg_pkg::stop_pulse_t stop_pulse_option_param_r;
  logic [15:0] feedforward_mode_param_r;
  logic [15:0] gear_numerator_first_r;
  logic [15:0] gear_numerator_second_r;
  logic [15:0] low_speed_comp_strength_r;
  logic [15:0] rdata_r;
  logic [15:0] fifo_out;
  logic fifo_valid;
  logic fifo_pop;
  logic [15:0] err_r;
  logic [2:0] fifo_level_r;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      gear_encoder_option_param_r <= `RST_GEAR_ENC;
      compensation_option_param_r <= `RST_COMP;
      stop_pulse_option_param_r <= `RST_STOP_PULSE;
      feedforward_mode_param_r <= `RST_FF_MODE;
      gear_numerator_first_r <= `RST_NUM_FIRST;
      gear_numerator_second_r <= `RST_NUM_SECOND;
      low_speed_comp_strength_r <= `RST_COMP_STRENGTH;
    end else if (wr_stb) begin
      unique case (addr)
        `REG_GEAR_ENC: gear_encoder_option_param_r <= wdata;
        `REG_COMP: compensation_option_param_r <= wdata;
        `REG_STOP_PULSE: stop_pulse_option_param_r <= wdata;
        `REG_FF_MODE: feedforward_mode_param_r <= wdata;
        `REG_NUM_FIRST: gear_numerator_first_r <= wdata;
        `REG_NUM_SECOND: gear_numerator_second_r <= wdata;
        `REG_COMP_STRENGTH: low_speed_comp_strength_r <= wdata;
        default: ;
      endcase
    end
  end

  assign fifo_pop = rd_stb && (addr == `REG_FIFO_DATA) && fifo_valid;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rdata_r <= 16'h0000;
    end else if (rd_stb) begin
      unique case (addr)
        `REG_GEAR_ENC: rdata_r <= gear_encoder_option_param_r;
        `REG_COMP: rdata_r <= compensation_option_param_r;
        `REG_STOP_PULSE: rdata_r <= stop_pulse_option_param_r;
        `REG_FF_MODE: rdata_r <= feedforward_mode_param_r;
        `REG_NUM_FIRST: rdata_r <= gear_numerator_first_r;
        `REG_NUM_SECOND: rdata_r <= gear_numerator_second_r;
        `REG_COMP_STRENGTH: rdata_r <= low_speed_comp_strength_r;
        `REG_POS_COUNT: rdata_r <= err_r;
        `REG_STATUS: rdata_r <= {9'h000, fifo_level_r, gear_numerator == gear_numerator_second_r,
                                 stop_action.zero_clamp, fifo_valid, gear_seq_error};
        `REG_FIFO_DATA: rdata_r <= fifo_valid ? fifo_out : 16'h0000;
        default: rdata_r <= 16'h0000;
      endcase
    end else begin
      rdata_r <= 16'h0000;
    end
  end
  assign rdata = rdata_r;

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [2:0] pls_s;
  logic [2:0] dir_s;
  logic [2:0] gsw_s;
  logic pls_q;
  logic dir_q;
  logic gsw_q;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pls_s <= 3'h0;
      dir_s <= 3'h0;
      gsw_s <= 3'h0;
      pls_q <= 1'b0;
      dir_q <= 1'b0;
      gsw_q <= 1'b0;
    end else begin
      pls_s <= {pls_s[1:0], reference_pulse_line.pulse_in};
      dir_s <= {dir_s[1:0], reference_pulse_line.dir_in};
      gsw_s <= {gsw_s[1:0], gear_switch_input};
      // accept a change only once stages two and three agree
      if (pls_s[1] == pls_s[2]) pls_q <= pls_s[2];
      if (dir_s[1] == dir_s[2]) dir_q <= dir_s[2];
      if (gsw_s[1] == gsw_s[2]) gsw_q <= gsw_s[2];
    end
  end

  // ****************************************
  // pulse decode
  // ****************************************
  logic a_in;
  logic b_in;
  logic a_prev_r;
  logic b_prev_r;
  logic step_fwd;
  logic step_rev;
  logic a_rise;
  logic a_fall;
  logic b_rise;
  logic b_fall;
  logic [3:0] form;

  assign form = stop_pulse_option_param_r.form;
  always_comb begin
    a_in = pls_q ^ stop_pulse_option_param_r.invert[1];
    b_in = dir_q ^ (stop_pulse_option_param_r.invert == 4'h3);
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      a_prev_r <= 1'b0;
      b_prev_r <= 1'b0;
    end else begin
      a_prev_r <= a_in;
      b_prev_r <= b_in;
    end
  end
  assign a_rise = a_in && !a_prev_r;
  assign a_fall = !a_in && a_prev_r;
  assign b_rise = b_in && !b_prev_r;
  assign b_fall = !b_in && b_prev_r;

  always_comb begin
    step_fwd = 1'b0;
    step_rev = 1'b0;
    unique case (form)
      4'h0: begin
        step_fwd = a_rise && !b_in;
        step_rev = a_rise && b_in;
      end
      4'h1: begin
        step_fwd = a_rise && !b_rise;
        step_rev = b_rise && !a_rise;
      end
      4'h2: begin
        step_fwd = a_rise && !b_in;
        step_rev = a_fall && !b_in;
      end
      4'h3: begin
        step_fwd = (a_rise && !b_in) || (a_fall && b_in);
        step_rev = (a_fall && !b_in) || (a_rise && b_in);
      end
      4'h4: begin
        step_fwd = (a_rise && !b_in) || (a_fall && b_in) || (b_rise && a_in) || (b_fall && !a_in);
        step_rev = (a_fall && !b_in) || (a_rise && b_in) || (b_fall && a_in) || (b_rise && !a_in);
      end
      default: ;
    endcase
  end

  // ****************************************
  // gear switch and quiet-time check
  // ****************************************
  logic gsw_prev_r;
  logic [$clog2(GEAR_QUIET_CYCLES+1)-1:0] quiet_r;
  logic quiet_ok;
  logic after_sw_r;
  logic seq_err_r;
  logic [15:0] num_r;
  assign quiet_ok = (quiet_r == $bits(quiet_r)'(GEAR_QUIET_CYCLES));

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      quiet_r <= '0;
      gsw_prev_r <= 1'b0;
      after_sw_r <= 1'b0;
      seq_err_r <= 1'b0;
    end else begin
      gsw_prev_r <= gsw_q;
      if (step_fwd || step_rev || (gsw_q != gsw_prev_r)) begin
        quiet_r <= '0;
      end else if (!quiet_ok) begin
        quiet_r <= quiet_r + 1'b1;
      end
      // window after a switch in which any pulse is a sequence fault
      if (gsw_q != gsw_prev_r) begin
        after_sw_r <= 1'b1;
      end else if (quiet_ok) begin
        after_sw_r <= 1'b0;
      end
      // pulses too close to a switch on either side; set wins over the clear
      if (((gsw_q != gsw_prev_r) && !quiet_ok) || ((step_fwd || step_rev) && after_sw_r)) begin
        seq_err_r <= 1'b1;
      end else if (wr_stb && addr == `REG_NUM_SECOND) begin
        seq_err_r <= 1'b0;
      end
    end
  end
  assign gear_seq_error = seq_err_r;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      num_r <= `RST_NUM_FIRST;
    end else begin
      num_r <= gsw_q ? gear_numerator_second_r : gear_numerator_first_r;
    end
  end
  assign gear_numerator = num_r;

  // ****************************************
  // stop mode
  // ****************************************
  pulse_cfg_pkg::stop_out_t stop_r;
  logic [3:0] smode;
  assign smode = stop_pulse_option_param_r.stop;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      stop_r <= '0;
    end else begin
      stop_r <= '0;
      if (overtravel && smode >= 4'h2 && smode <= 4'h6) begin
        stop_r.plug_brake <= 1'b1;
        stop_r.zero_clamp <= smode >= 4'h4;
        stop_r.coast <= smode < 4'h4;
      end else if (!servo_on || overtravel) begin
        unique case (smode)
          4'h0, 4'h2, 4'h4: stop_r.dyn_brake <= 1'b1;
          default: stop_r.coast <= 1'b1;
        endcase
      end
    end
  end
  assign stop_action = stop_r;
  assign dynamic_brake = stop_r.dyn_brake;

  // ****************************************
  // error counter and step fifo
  // ****************************************
  logic clr_now;
  logic clamp_now;
  logic fifo_in_ready;
  logic fifo_in_valid;
  // zero clamp decided from the inputs, so the first overtravel cycle cannot clear
  assign clamp_now = overtravel && smode >= 4'h4 && smode <= 4'h6;
  always_comb begin
    unique case (stop_pulse_option_param_r.clear)
      4'h1: clr_now = 1'b0;
      4'h2: clr_now = (!servo_on || overtravel) && !clamp_now;
      default: clr_now = !servo_on;
    endcase
  end

  assign fifo_in_valid = step_fwd || step_rev;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      err_r <= 16'h0000;
    end else if (clr_now) begin
      err_r <= 16'h0000;
    end else if (step_fwd) begin
      err_r <= err_r + 16'h0001;
    end else if (step_rev) begin
      err_r <= err_r - 16'h0001;
    end
  end
  assign pos_error = err_r;

  // fifo keeps a history of counter values; when full the history drops, counting goes on
  step_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(step_fwd ? err_r + 16'h0001 : err_r - 16'h0001),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out)
  );

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      fifo_level_r <= 3'h0;
    end else begin
      fifo_level_r <= fifo_level_r + 3'((fifo_in_valid && fifo_in_ready)) - 3'(fifo_pop);
    end
  end

  // ****************************************
  // option outputs
  // ****************************************
  assign absolute_mode = !gear_encoder_option_param_r[8];
  assign low_speed_comp_en = compensation_option_param_r[8];
  assign low_speed_comp_level = compensation_option_param_r[8] ? low_speed_comp_strength_r : 16'h0000;
  assign overload_enhance = compensation_option_param_r[12];
  assign high_speed_ff = feedforward_mode_param_r[1];
  assign analog_ff_en = feedforward_mode_param_r[0];

  // ****************************************
  // assertions
  // ****************************************
  property p_inv_both;
    @(posedge clk_sys) disable iff (!rstn)
      (stop_pulse_option_param_r.invert == 4'h3) |-> (b_in == !dir_q);
  endproperty
  a_inv_both: assert property (p_inv_both) else $error("dir not inverted");
  property p_no_clear;
    @(posedge clk_sys) disable iff (!rstn)
      (stop_pulse_option_param_r.clear == 4'h1 && !fifo_in_valid) |=> (err_r == $past(err_r));
  endproperty
  a_no_clear: assert property (p_no_clear) else $error("counter changed");
  property p_def_clear;
    @(posedge clk_sys) disable iff (!rstn)
      (stop_pulse_option_param_r.clear == 4'h0 && !servo_on) |=> (err_r == 16'h0000);
  endproperty
  a_def_clear: assert property (p_def_clear) else $error("not cleared");
  property p_coast;
    @(posedge clk_sys) disable iff (!rstn)
      (smode == 4'h1 && !servo_on) |=> stop_r.coast && !stop_r.dyn_brake;
  endproperty
  a_coast: assert property (p_coast) else $error("no coast");
  property p_plug;
    @(posedge clk_sys) disable iff (!rstn)
      (overtravel && smode == 4'h5) |=> stop_r.plug_brake && stop_r.zero_clamp;
  endproperty
  a_plug: assert property (p_plug) else $error("no plug brake");
  property p_gear;
    @(posedge clk_sys) disable iff (!rstn)
      gsw_q |=> (gear_numerator == $past(gear_numerator_second_r));
  endproperty
  a_gear: assert property (p_gear) else $error("wrong numerator");
  property p_seq;
    @(posedge clk_sys) disable iff (!rstn)
      ((gsw_q != gsw_prev_r) && !quiet_ok) |=> gear_seq_error;
  endproperty
  a_seq: assert property (p_seq) else $error("error missed");
  property p_seq_after;
    @(posedge clk_sys) disable iff (!rstn)
      ((step_fwd || step_rev) && after_sw_r) |=> gear_seq_error;
  endproperty
  a_seq_after: assert property (p_seq_after) else $error("late pulse missed");
  property p_step;
    @(posedge clk_sys) disable iff (!rstn)
      (form == 4'h0 && a_rise && !b_in && !clr_now) |=>
        (err_r == $past(err_r) + 16'h0001);
  endproperty
  a_step: assert property (p_step) else $error("step not counted");
endmodule : servo_reference_pulse_config

// [dv/host_pulse_model.sv]
// host-side model driving the reference pulse pins and the gear switch
`timescale 1ns/100ps
module host_pulse_model #(
  parameter int QUIET = 20
) (
  input wire logic clk_sys,
  output pulse_cfg_pkg::ref_pins_t pins,
  output logic gear_sw
);
  // ****************
  // pin sequencing
  // ****************
  initial begin
    pins = '0;
    gear_sw = 1'b0;
  end
  // each level is held 4 cycles so the input synchroniser never misses an edge
  task automatic put(input logic p, input logic d);
    @(posedge clk_sys);
    pins <= {p, d};
    repeat (3) @(posedge clk_sys);
  endtask : put
  // direction settles before the first pulse edge, to avoid a sampling race
  task automatic steps(input int n, input logic d);
    put(1'b0, d);
    repeat (n) begin
      put(1'b1, d);
      put(1'b0, d);
    end
  endtask : steps
  task automatic back_pulses(input int n);
    repeat (n) begin
      put(1'b0, 1'b1);
      put(1'b0, 1'b0);
    end
  endtask : back_pulses
  task automatic quad(input int k, input logic rev);
    repeat (k) begin
      put(!rev, rev);
      put(1'b1, 1'b1);
      put(rev, !rev);
      put(1'b0, 1'b0);
    end
  endtask : quad
  // quiet == 0 breaks the pulse-free interval on purpose
  task automatic gear(input logic lvl, input logic quiet);
    if (quiet) repeat (QUIET + 8) @(posedge clk_sys);
    @(posedge clk_sys);
    gear_sw <= lvl;
    if (quiet) repeat (QUIET + 8) @(posedge clk_sys);
  endtask : gear
endmodule : host_pulse_model

// [dv/testbench.sv]
// self-checking testbench for the reference pulse configuration block
`timescale 1ns/100ps
module testbench;
  localparam int QUIET = 20;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic servo_on = 1'b0;
  logic overtravel = 1'b0;
  pulse_cfg_pkg::ref_pins_t pins;
  pulse_cfg_pkg::stop_out_t stop_action;
  logic gear_sw, gear_seq_error, dynamic_brake, absolute_mode, low_speed_comp_en;
  logic overload_enhance, high_speed_ff, analog_ff_en;
  logic [15:0] gear_numerator, rdata, low_speed_comp_level, pos_error;
  int n_errors = 0;
  int checks_done = 0;
  always #25 clk_sys = ~clk_sys;
  servo_reference_pulse_config #(.GEAR_QUIET_CYCLES(QUIET), .FIFO_DEPTH(4))
    servo_reference_pulse_config_i (.clk_sys(clk_sys), .rstn(rstn), .addr(addr),
    .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
    .reference_pulse_line(pins), .gear_switch_input(gear_sw), .servo_on(servo_on),
    .overtravel(overtravel), .gear_numerator(gear_numerator),
    .gear_seq_error(gear_seq_error), .stop_action(stop_action),
    .dynamic_brake(dynamic_brake), .absolute_mode(absolute_mode),
    .low_speed_comp_en(low_speed_comp_en), .low_speed_comp_level(low_speed_comp_level),
    .overload_enhance(overload_enhance), .high_speed_ff(high_speed_ff),
    .analog_ff_en(analog_ff_en), .pos_error(pos_error));
  host_pulse_model #(.QUIET(QUIET)) host_pulse_model_i (.clk_sys(clk_sys), .pins(pins),
    .gear_sw(gear_sw));
  // ****************
  // common tasks
  // ****************
  task automatic wrap_up();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : wrap_up
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  // counting sign is a design choice, so only the magnitude is judged
  function automatic logic [15:0] mag(input logic [15:0] v);
    return v[15] ? -v : v;
  endfunction : mag
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : wt
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    wr_stb <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_sys);
    wr_stb <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    rd_stb <= 1'b1;
    addr <= a;
    @(posedge clk_sys);
    rd_stb <= 1'b0;
    #1 d = rdata;
  endtask : rd
  // config is changed with the servo off, which also clears the counter
  task automatic setup(input logic [15:0] v);
    @(posedge clk_sys);
    servo_on <= 1'b0;
    wr(4'h2, v);
    wt(6);
    servo_on <= 1'b1;
    wt(6);
  endtask : setup
  // ****************
  // scenarios
  // ****************
  task automatic t_regs();
    logic [15:0] d;
    logic [15:0] rst_v [7] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0001, 16'h0001,
      16'h0000};
    check(absolute_mode, 16'h0001);
    check(gear_numerator, 16'h0001);
    for (int i = 0; i < 8; i++) begin
      rd(i[3:0], d);
      check(d, (i < 7) ? rst_v[i] : 16'h0000);
    end
    wr(4'hf, 16'hffff);
    rd(4'hf, d);
    check(d, 16'h0000);
    wr(4'h0, 16'h0100);
    wt(2);
    check(absolute_mode, 16'h0000);
    wr(4'h1, 16'h1100);
    wr(4'h6, 16'h1234);
    wt(2);
    check(low_speed_comp_en, 16'h0001);
    check(low_speed_comp_level, 16'h1234);
    check(overload_enhance, 16'h0001);
    wr(4'h1, 16'h0000);
    wt(2);
    check(low_speed_comp_en, 16'h0000);
    check(low_speed_comp_level, 16'h0000);
    check(overload_enhance, 16'h0000);
    for (int v = 0; v < 4; v++) begin
      wr(4'h3, v[15:0]);
      wt(2);
      check(high_speed_ff, {15'h0, v >= 2});
      check(analog_ff_en, {15'h0, v[0]});
    end
    $display("test regs done");
  endtask : t_regs
  task automatic t_fifo();
    logic [15:0] s, d;
    int i;
    setup(16'h0000);
    for (i = 0; i < 8; i++) begin
      rd(4'h8, s);
      if (s[1] !== 1'b1) break;
      rd(4'h9, d);
    end
    check(s[1], 16'h0000);
    host_pulse_model_i.steps(6, 1'b0);
    wt(8);
    rd(4'h8, s);
    check(s[6:4], 16'h0004);
    check(s[1], 16'h0001);
    for (i = 1; i <= 4; i++) begin
      rd(4'h9, d);
      check(mag(d), i[15:0]);
    end
    rd(4'h8, s);
    check(s[1], 16'h0000);
    $display("test fifo done");
  endtask : t_fifo
  task automatic t_forms();
    logic [15:0] e1 [5] = '{16'h5, 16'h5, 16'h2, 16'h4, 16'h8};
    logic [15:0] e2 [5] = '{16'h3, 16'h3, 16'h1, 16'h2, 16'h4};
    for (int f = 0; f < 5; f++) begin
      setup({4'h0, f[3:0], 8'h00});
      if (f < 2) host_pulse_model_i.steps(5, 1'b0);
      else host_pulse_model_i.quad(2, 1'b0);
      wt(8);
      check(mag(pos_error), e1[f]);
      if (f == 0) host_pulse_model_i.steps(2, 1'b1);
      else if (f == 1) host_pulse_model_i.back_pulses(2);
      else host_pulse_model_i.quad(1, 1'b1);
      wt(8);
      check(mag(pos_error), e2[f]);
    end
    $display("test forms done");
  endtask : t_forms
  task automatic t_invert();
    logic [15:0] a;
    setup(16'h0000);
    host_pulse_model_i.steps(4, 1'b0);
    wt(8);
    a = pos_error;
    check(mag(a), 16'h0004);
    setup(16'h2000);
    host_pulse_model_i.steps(4, 1'b0);
    wt(8);
    check(pos_error, a);
    setup(16'h3000);
    host_pulse_model_i.steps(4, 1'b1);
    wt(8);
    check(pos_error, a);
    $display("test invert done");
  endtask : t_invert
  task automatic t_clear();
    setup(16'h0000);
    host_pulse_model_i.steps(3, 1'b0);
    overtravel <= 1'b1;
    wt(8);
    check(mag(pos_error), 16'h0003);
    servo_on <= 1'b0;
    wt(8);
    check(pos_error, 16'h0000);
    overtravel <= 1'b0;
    setup(16'h0010);
    host_pulse_model_i.steps(3, 1'b0);
    servo_on <= 1'b0;
    wt(8);
    check(mag(pos_error), 16'h0003);
    setup(16'h0020);
    host_pulse_model_i.steps(3, 1'b0);
    overtravel <= 1'b1;
    wt(8);
    check(pos_error, 16'h0000);
    overtravel <= 1'b0;
    setup(16'h0024);
    host_pulse_model_i.steps(3, 1'b0);
    overtravel <= 1'b1;
    wt(8);
    check(mag(pos_error), 16'h0003);
    overtravel <= 1'b0;
    $display("test clear done");
  endtask : t_clear
  task automatic t_stop();
    logic [3:0] e;
    for (int s = 0; s < 7; s++) begin
      setup({12'h000, s[3:0]});
      check(stop_action, 16'h0000);
      servo_on <= 1'b0;
      wt(6);
      e = (s == 0 || s == 2 || s == 4) ? 4'h8 : 4'h4;
      check(stop_action, e);
      check(dynamic_brake, e[3]);
      servo_on <= 1'b1;
      wt(6);
      if (s >= 2) begin
        overtravel <= 1'b1;
        wt(6);
        check(stop_action, {1'b0, s < 4, 1'b1, s >= 4});
        overtravel <= 1'b0;
        wt(6);
      end
    end
    $display("test stop done");
  endtask : t_stop
  task automatic t_gear();
    logic [15:0] s;
    int i;
    wr(4'h4, 16'h0003);
    wr(4'h5, 16'h0007);
    wt(6);
    check(gear_numerator, 16'h0003);
    host_pulse_model_i.gear(1'b1, 1'b1);
    check(gear_numerator, 16'h0007);
    rd(4'h8, s);
    check(s[3], 16'h0001);
    host_pulse_model_i.gear(1'b0, 1'b1);
    check(gear_numerator, 16'h0003);
    check(gear_seq_error, 16'h0000);
    host_pulse_model_i.gear(1'b1, 1'b0);
    host_pulse_model_i.steps(1, 1'b0);
    for (i = 0; i < 60 && gear_seq_error !== 1'b1; i++) @(posedge clk_sys);
    if (i == 60) begin
      n_errors++;
      $display("ERROR at %0t: no gear sequence error", $time);
      return;
    end
    rd(4'h8, s);
    check(s[0], 16'h0001);
    wr(4'h5, 16'h0007);
    wt(QUIET + 8);
    check(gear_seq_error, 16'h0000);
    host_pulse_model_i.steps(1, 1'b0);
    host_pulse_model_i.gear(1'b0, 1'b0);
    wt(8);
    check(gear_seq_error, 16'h0001);
    $display("test gear done");
  endtask : t_gear
  initial begin
    wt(6);
    rstn <= 1'b1;
    t_regs();
    t_fifo();
    t_forms();
    t_invert();
    t_clear();
    t_stop();
    t_gear();
    wrap_up();
  end
endmodule : testbench
